//--- src/sst_bus_front.sv
`timescale 1ns/10ps
`default_nettype none
`include "sst_defs.svh"

module sst_bus_front #(
    parameter int unsigned TMO_CYC  = `SST_TMO_CYC,
    parameter int unsigned INIT_CYC = `SST_INIT_CYC
) (
    // System
    input  wire logic       clk,
    input  wire logic       srst,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // User side
    input  wire logic       drive_low,
    output logic            ready,
    output logic            frame_active,
    output logic            start_seen,
    output logic            stop_seen,
    output logic            scl_fell,
    output logic            bit_valid,
    output logic            bit_data,
    output logic            byte_valid,
    output logic [7:0]      rx_byte,
    output logic            ack_slot,
    output logic            timeout
);

    // ****************************************
    // Filtered lines and edges
    // ****************************************
    logic                   scl_f;
    logic                   sda_f;
    logic                   scl_d;
    logic                   sda_d;
    sst_pkg::sst_state_e    state;
    logic [`SST_TMO_W-1:0]  tmo_cnt;
    logic [`SST_INIT_W-1:0] init_cnt;
    logic [3:0]             bit_idx;
    logic                   start_ev;
    logic                   stop_ev;
    logic                   scl_rise;
    logic                   scl_fall;
    logic                   tmo_hit;
    logic                   in_frame;

    // Filter delay of ~65 ns keeps data-out hold under fast-plus limit
    sst_glitch_filter #(.LIM(`SST_GLITCH_CYC)) u_scl_flt (
        .clk   (clk),
        .srst  (srst),
        .pin   (scl_in),
        .level (scl_f)
    );

    sst_glitch_filter #(.LIM(`SST_GLITCH_CYC)) u_sda_flt (
        .clk   (clk),
        .srst  (srst),
        .pin   (sda_in),
        .level (sda_f)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            scl_d <= `SST_LINE_IDLE;
            sda_d <= `SST_LINE_IDLE;
        end else begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    assign start_ev = scl_f && scl_d && sda_d && !sda_f;
    assign stop_ev  = scl_f && scl_d && !sda_d && sda_f;
    assign scl_rise = scl_f && !scl_d;
    assign scl_fall = !scl_f && scl_d;
    assign in_frame = (state == sst_pkg::SST_FRAME);
    assign tmo_hit  = in_frame && !scl_f
                      && (tmo_cnt == `SST_TMO_W'(TMO_CYC - 1));

    // ****************************************
    // Interface state
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= sst_pkg::SST_BOOT;
        end else begin
            case (state)
                sst_pkg::SST_BOOT: begin
                    if (init_cnt == `SST_INIT_W'(INIT_CYC - 1)) begin
                        state <= sst_pkg::SST_IDLE;
                    end
                end
                sst_pkg::SST_IDLE: begin
                    if (start_ev) begin
                        state <= sst_pkg::SST_FRAME;
                    end
                end
                sst_pkg::SST_FRAME: begin
                    if (stop_ev || tmo_hit) begin
                        state <= sst_pkg::SST_IDLE;
                    end
                end
                default: begin
                    state <= sst_pkg::SST_IDLE;
                end
            endcase
        end
    end

    // Power-up delay; starts before it ends are ignored
    always_ff @(posedge clk) begin
        if (srst) begin
            init_cnt <= '0;
            ready    <= 1'b0;
        end else if (state == sst_pkg::SST_BOOT) begin
            init_cnt <= init_cnt + `SST_INIT_W'(1);
            if (init_cnt == `SST_INIT_W'(INIT_CYC - 1)) begin
                ready <= 1'b1;
            end
        end
    end

    // ****************************************
    // Clock-low timeout
    // ****************************************
    // Runs on clk, so a stopped bus clock is still measured
    always_ff @(posedge clk) begin
        if (srst) begin
            tmo_cnt <= '0;
        end else if (!in_frame || scl_f || tmo_hit || start_ev) begin
            tmo_cnt <= '0;
        end else begin
            tmo_cnt <= tmo_cnt + `SST_TMO_W'(1);
        end
    end

    // ****************************************
    // Frame events and bit capture
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            frame_active <= 1'b0;
            start_seen   <= 1'b0;
            stop_seen    <= 1'b0;
            timeout      <= 1'b0;
            scl_fell     <= 1'b0;
        end else begin
            start_seen <= (state != sst_pkg::SST_BOOT) && start_ev;
            stop_seen  <= in_frame && stop_ev;
            timeout    <= tmo_hit;
            scl_fell   <= in_frame && scl_fall;
            if (state == sst_pkg::SST_IDLE && start_ev) begin
                frame_active <= 1'b1;
            end else if (in_frame && (stop_ev || tmo_hit)) begin
                frame_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bit_idx    <= '0;
            bit_valid  <= 1'b0;
            bit_data   <= 1'b0;
            byte_valid <= 1'b0;
            rx_byte    <= '0;
            ack_slot   <= 1'b0;
        end else begin
            bit_valid  <= 1'b0;
            byte_valid <= 1'b0;
            if (!in_frame || start_ev || tmo_hit) begin
                bit_idx  <= '0;
                ack_slot <= 1'b0;
            end else if (scl_rise) begin
                bit_valid <= 1'b1;
                bit_data  <= sda_f;
                ack_slot  <= (bit_idx == 4'h7);
                if (bit_idx == 4'h8) begin
                    bit_idx <= '0;
                end else begin
                    bit_idx <= bit_idx + 4'h1;
                    rx_byte <= {rx_byte[6:0], sda_f};
                    byte_valid <= (bit_idx == 4'h7);
                end
            end
        end
    end

    // ****************************************
    // Open-drain data output
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= !(in_frame && drive_low && !tmo_hit && !stop_ev);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [`SST_TMO_W:0] low_run;

    always_ff @(posedge clk) begin
        if (srst || scl_f) begin
            low_run <= '0;
        end else if (!low_run[`SST_TMO_W]) begin
            low_run <= low_run + (`SST_TMO_W+1)'(1);
        end
    end

    sequence s_start;
        scl_f && scl_d && sda_d && !sda_f;
    endsequence

    sequence s_stop;
        scl_f && scl_d && !sda_d && sda_f;
    endsequence

    chk_tmo_abort: assert property (
        @(posedge clk) disable iff (srst)
        tmo_hit |=> timeout && !frame_active && state == sst_pkg::SST_IDLE
    ) else $error("timeout did not return interface to idle");

    chk_no_early: assert property (
        @(posedge clk) disable iff (srst)
        $rose(timeout) |-> $past(low_run) >= (`SST_TMO_W+1)'(TMO_CYC - 1)
    ) else $error("timeout before full clock-low interval");

    chk_tmo_release: assert property (
        @(posedge clk) disable iff (srst)
        timeout |-> sda_oe_n ##1 sda_oe_n
    ) else $error("data line driven after timeout");

    chk_count_gate: assert property (
        @(posedge clk) disable iff (srst)
        (!in_frame || scl_f) |=> tmo_cnt == '0
    ) else $error("timeout counted outside frame or clock high");

    chk_ready_delay: assert property (
        @(posedge clk) disable iff (srst)
        $rose(ready) |-> $past(init_cnt) == `SST_INIT_W'(INIT_CYC - 1)
                         && state == sst_pkg::SST_IDLE
    ) else $error("ready at wrong moment");

    chk_boot_deaf: assert property (
        @(posedge clk) disable iff (srst)
        !ready |-> !frame_active && sda_oe_n
    ) else $error("bus activity before ready");

    chk_start_detect: assert property (
        @(posedge clk) disable iff (srst)
        (state == sst_pkg::SST_IDLE) ##0 s_start |=> start_seen && frame_active
    ) else $error("start condition missed");

    chk_stop_detect: assert property (
        @(posedge clk) disable iff (srst)
        in_frame ##0 s_stop |=> stop_seen && !frame_active ##1 sda_oe_n
    ) else $error("stop condition missed");

    chk_idle_release: assert property (
        @(posedge clk) disable iff (srst)
        !in_frame |=> sda_oe_n
    ) else $error("data line driven outside a frame");

endmodule : sst_bus_front
`default_nettype wire

//--- src/sst_defs.svh
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH

// ****************************************
// Clock
// ****************************************
`define SST_CLK_MHZ          200
`define SST_CLK_KHZ          200000
`define SST_CLK_NS           5

// ****************************************
// Bus timing
// ****************************************
// clock_low_abort_interval window, ms
`define SST_TMO_MIN_MS       25
`define SST_TMO_MAX_MS       35
// Trip point sits mid-window to absorb clock tolerance
`define SST_TMO_TRIP_MS      ((`SST_TMO_MIN_MS + `SST_TMO_MAX_MS) / 2)
`define SST_TMO_CYC          (`SST_TMO_TRIP_MS * `SST_CLK_KHZ)
// power_up_ready_delay, us
`define SST_INIT_US          500
`define SST_INIT_CYC         (`SST_INIT_US * `SST_CLK_MHZ)
// glitch_reject_width, ns; a level must outlast it by one sample
`define SST_GLITCH_NS        50
`define SST_GLITCH_CYC       (`SST_GLITCH_NS / `SST_CLK_NS + 1)

// ****************************************
// Widths and reset values
// ****************************************
`define SST_TMO_W            23
`define SST_INIT_W           17
`define SST_FLT_W            8
`define SST_LINE_IDLE        1'b1

`endif

//--- src/sst_glitch_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "sst_defs.svh"

module sst_glitch_filter #(
    parameter int unsigned LIM = `SST_GLITCH_CYC
) (
    // System
    input  wire logic clk,
    input  wire logic srst,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);

    logic                  s1;
    logic                  s2;
    logic [`SST_FLT_W-1:0] cnt;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1 <= `SST_LINE_IDLE;
            s2 <= `SST_LINE_IDLE;
        end else begin
            s1 <= pin;
            s2 <= s1;
        end
    end

    // Level follows only after LIM agreeing samples
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt   <= '0;
            level <= `SST_LINE_IDLE;
        end else if (s2 == level) begin
            cnt <= '0;
        end else if (cnt == `SST_FLT_W'(LIM - 1)) begin
            cnt   <= '0;
            level <= s2;
        end else begin
            cnt <= cnt + `SST_FLT_W'(1);
        end
    end

    chk_glitch_reject: assert property (
        @(posedge clk) disable iff (srst)
        $changed(level) |-> $past(cnt) == `SST_FLT_W'(LIM - 1)
    ) else $error("filtered level moved before pulse width limit");

endmodule : sst_glitch_filter
`default_nettype wire

//--- src/sst_pkg.sv
`default_nettype none

package sst_pkg;

    // Interface state, one-hot
    typedef enum logic [2:0] {
        SST_BOOT  = 3'b001,
        SST_IDLE  = 3'b010,
        SST_FRAME = 3'b100
    } sst_state_e;

endpackage : sst_pkg

`default_nettype wire

//--- tb/sst_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module sst_host_model (
    // Timing reference
    input  wire logic clk,
    // Bus lines, released data reads high
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // Data falls with clock high, clock then parked low
    // Data released first, then clock raised, so a repeated start works too
    task automatic start();
        @(negedge clk);
        sda_drv = 1'b1;
        #80;
        scl = 1'b1;
        #80;
        sda_drv = 1'b0;
        #160;
        scl = 1'b0;
        #80;
    endtask : start

    // Low half 80 ns, far below the abort interval
    task automatic send_bit(input logic b);
        sda_drv = b;
        #40;
        scl = 1'b1;
        #80;
        scl = 1'b0;
        #40;
    endtask : send_bit

    task automatic stop();
        sda_drv = 1'b0;
        #40;
        scl = 1'b1;
        #80;
        sda_drv = 1'b1;
        #160;
    endtask : stop

    // Stalled clock, only where a test wants it
    task automatic park_low(input int n);
        @(negedge clk);
        scl = 1'b0;
        repeat (n) @(negedge clk);
    endtask : park_low

    // Clock pulse no wider than the reject width
    task automatic clk_glitch();
        @(negedge clk);
        scl = ~scl;
        #50;
        scl = ~scl;
        #200;
    endtask : clk_glitch

    task automatic glitch();
        @(negedge clk);
        sda_drv = 1'b0;
        #50;
        sda_drv = 1'b1;
        #200;
    endtask : glitch
endmodule : sst_host_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam int unsigned TMO = 200;
    localparam int unsigned INI = 100;
    logic       clk, srst, drive_low, sda_in, scl, host_sda;
    logic       sda_out, sda_oe_n, ready, frame_active, start_seen;
    logic       stop_seen, bit_data, byte_valid, ack_slot, timeout;
    logic       scl_fell, bit_valid;
    logic [7:0] rx_byte;
    int         failures, cmp_count, cyc, n_st, n_sp, n_by, n_to;
    int         n_fl, n_bv;

    // Open drain with pull-up
    assign sda_in = host_sda & (sda_oe_n | sda_out);

    sst_host_model sst_host_model_i (
        .clk     (clk),
        .scl     (scl),
        .sda_drv (host_sda)
    );

    sst_bus_front #(
        .TMO_CYC  (TMO),
        .INIT_CYC (INI)
    ) sst_bus_front_i (
        .clk          (clk),
        .srst         (srst),
        .scl_in       (scl),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe_n     (sda_oe_n),
        .drive_low    (drive_low),
        .ready        (ready),
        .frame_active (frame_active),
        .start_seen   (start_seen),
        .stop_seen    (stop_seen),
        .scl_fell     (scl_fell),
        .bit_valid    (bit_valid),
        .bit_data     (bit_data),
        .byte_valid   (byte_valid),
        .rx_byte      (rx_byte),
        .ack_slot     (ack_slot),
        .timeout      (timeout)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************
    // Pulse counters and hang guard
    // ****************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_st <= n_st + (start_seen === 1'b1);
        n_sp <= n_sp + (stop_seen === 1'b1);
        n_by <= n_by + (byte_valid === 1'b1);
        n_to <= n_to + (timeout === 1'b1);
        n_fl <= n_fl + (scl_fell === 1'b1);
        n_bv <= n_bv + (bit_valid === 1'b1);
        if (cyc == 10000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_boot();
        srst = 1'b1;
        // Count rising edges: the first clock value is not an edge
        repeat (3) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        check(ready, 8'h0);
        check(sda_oe_n, 8'h1);
        sst_host_model_i.start();
        check(ready, 8'h0);
        check(n_st, 8'h0);
        sst_host_model_i.stop();
        check(ready, 8'h1);
        check(n_sp, 8'h0);
        $display("boot test done");
    endtask : test_boot

    task automatic test_byte();
        int         s;
        int         b;
        int         f;
        int         v;
        logic [7:0] d;
        s = n_st;
        b = n_by;
        f = n_fl;
        v = n_bv;
        d = 8'ha5;
        sst_host_model_i.start();
        check(n_st - s, 8'h1);
        sst_host_model_i.clk_glitch();
        check(n_bv - v, 8'h0);
        for (int i = 7; i >= 0; i--) sst_host_model_i.send_bit(d[i]);
        check(rx_byte, 8'ha5);
        check(n_by - b, 8'h1);
        check(n_bv - v, 8'h8);
        check(bit_data, 8'h1);
        check(ack_slot, 8'h1);
        drive_low = 1'b1;
        repeat (2) @(negedge clk);
        check(sda_in, 8'h0);
        check(sda_out, 8'h0);
        sst_host_model_i.send_bit(1'b1);
        drive_low = 1'b0;
        check(bit_data, 8'h0);
        check(ack_slot, 8'h0);
        s = n_sp;
        sst_host_model_i.stop();
        check(n_sp - s, 8'h1);
        check(frame_active, 8'h0);
        check(n_fl - f, 8'ha);
        $display("byte test done");
    endtask : test_byte

    task automatic test_timeout();
        int t;
        int p;
        t = n_to;
        sst_host_model_i.start();
        // Just under the minimum abort time
        sst_host_model_i.park_low(150);
        check(frame_active, 8'h1);
        sst_host_model_i.send_bit(1'b0);
        drive_low = 1'b1;
        repeat (2) @(negedge clk);
        check(sda_oe_n, 8'h0);
        sst_host_model_i.park_low(TMO + 20);
        check(n_to - t, 8'h1);
        check(frame_active, 8'h0);
        check(sda_oe_n, 8'h1);
        drive_low = 1'b0;
        p = n_sp;
        sst_host_model_i.stop();
        check(n_sp - p, 8'h0);
        sst_host_model_i.start();
        check(frame_active, 8'h1);
        // Repeated start keeps the frame open
        p = n_st;
        sst_host_model_i.start();
        check(n_st - p, 8'h1);
        check(frame_active, 8'h1);
        sst_host_model_i.stop();
        $display("timeout test done");
    endtask : test_timeout

    task automatic test_idle_glitch();
        int t;
        int s;
        int f;
        t = n_to;
        s = n_st;
        f = n_fl;
        sst_host_model_i.park_low(2 * TMO);
        sst_host_model_i.stop();
        check(n_to - t, 8'h0);
        check(n_fl - f, 8'h0);
        sst_host_model_i.glitch();
        check(n_st - s, 8'h0);
        check(frame_active, 8'h0);
        $display("idle and glitch test done");
    endtask : test_idle_glitch

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    initial begin
        srst = 1'b1;
        drive_low = 1'b0;
        {failures, cmp_count, cyc, n_st, n_sp, n_by, n_to} = '0;
        {n_fl, n_bv} = '0;
        test_boot();
        test_byte();
        test_timeout();
        test_idle_glitch();
        final_report();
    end
endmodule : tb

`default_nettype wire
